// ==== pulse_gen_pkg.sv ====
// Package with register map, field layouts and constants of the pulse generator.
`default_nettype none
package pulse_gen_pkg;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_MODE      = 8'h04;
  localparam logic [7:0]  OFS_CYC_LO    = 8'h08;
  localparam logic [7:0]  OFS_CYC_HI    = 8'h0C;
  localparam logic [7:0]  OFS_DUTY_LO   = 8'h10;
  localparam logic [7:0]  OFS_DUTY_HI   = 8'h14;
  localparam logic [7:0]  OFS_SYS       = 8'h18;
  localparam logic [7:0]  OFS_STATUS    = 8'h1C;

  localparam logic [1:0]  MODE_PPG16    = 2'h3;
  localparam logic [15:0] COUNT_ZERO    = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;
  localparam int          PRESCALE_W    = 11;
  localparam int          FS_DIV_W      = 4;

  localparam logic [2:0]  CK_DIV2048    = 3'h0;
  localparam logic [2:0]  CK_DIV1024    = 3'h1;
  localparam logic [2:0]  CK_DIV256     = 3'h2;
  localparam logic [2:0]  CK_DIV64      = 3'h3;
  localparam logic [2:0]  CK_DIV16      = 3'h4;
  localparam logic [2:0]  CK_DIV4       = 3'h5;
  localparam logic [2:0]  CK_DIV2       = 3'h6;
  localparam logic [2:0]  CK_DIV1       = 3'h7;

  // Control word: bit 0 run, bit 1 cascade.
  typedef struct packed {
    logic [5:0] unused;
    logic       cascade_select;
    logic       run_bit;
  } pair_ctrl_t;

  // Upper timer mode word.
  typedef struct packed {
    logic       initial_level_bit;
    logic       double_buffer_enable;
    logic [1:0] mode_field;
    logic       external_clock_select;
    logic [2:0] clock_select_field;
  } upper_mode_t;

  // System word: bit 0 divider select, bit 1 slow or sleep operation.
  typedef struct packed {
    logic [5:0] unused;
    logic       slow_mode;
    logic       divider_select_bit;
  } sys_ctrl_t;

  typedef struct packed {
    logic [15:0] cycle_value16;
    logic [15:0] duty_value16;
  } compare_pair_t;
endpackage
`default_nettype wire

// ==== pulse_gen.sv ====
// Cascaded 16-bit programmable pulse generator with an APB register port.
//
// Function
// (RQ1) Cascade bit joins timers; upper settings only.
// (RQ2) Mode field value 11 selects pulse generator.
// (RQ3) Source bit picks prescaled or external clock.
// (RQ4) Codes 000..111 divide main clock 2^11..1.
// (RQ5) Divider bit or slow mode selects low-frequency.
// (RQ6) External clock limited; two cycles each phase.
// (RQ7) Upper duty write commits all four bytes.
// (RQ8) Software writes the upper duty byte last.
// (RQ9) Stopped pin shows the initial-level bit.
// (RQ10) Run bit starts the counter on source clock.
// (RQ11) Duty match inverts pin, raises first irq.
// (RQ12) Cycle match restores pin, irq, clears count.
// (RQ13) Clearing run stops, clears, restores pin.
// (RQ14) Double buffer used when enable bit is 1.
// (RQ15) Running commits buffered until cycle match.
// (RQ16) Stopped commits load buffer and comparators.
// (RQ17) Without buffer commits load comparators at once.
// (RQ18) Value below count waits for the wrap.
// (RQ19) Value equal to count matches right away.
// (RQ20) Reads return last written values.
// (RQ21) Buffered values move only at cycle boundary.
// (RQ22) Count wraps past 0xFFFF without toggling.
`timescale 1ns/1ps
`default_nettype none
module pulse_gen (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        low_freq_clock,
  input  wire logic        ext_clock_in,
  output logic             pulse_output_pin,
  output logic             duty_match_irq,
  output logic             cycle_match_irq
);
  localparam int PW = pulse_gen_pkg::PRESCALE_W;
  localparam int FW = pulse_gen_pkg::FS_DIV_W;

  pulse_gen_pkg::pair_ctrl_t    ctrl_q;
  pulse_gen_pkg::upper_mode_t   mode_q;
  pulse_gen_pkg::sys_ctrl_t     sys_q;
  pulse_gen_pkg::compare_pair_t buf_q;
  pulse_gen_pkg::compare_pair_t act_q;
  logic [7:0]    cyc_lo_q;
  logic [7:0]    cyc_hi_q;
  logic [7:0]    duty_lo_q;
  logic [7:0]    duty_hi_q;
  logic [15:0]   cnt_q;
  logic [PW-1:0] pre_q;
  logic [FW-1:0] fsdiv_q;
  logic          fs_prev_q;
  logic          ext_prev_q;
  logic          check_q;
  logic          pin_q;
  logic          duty_irq_q;
  logic          cyc_irq_q;
  logic [31:0]   prdata_q;
  logic          pready_q;
  logic          pslverr_q;

  // Divider tap for a main-clock code; all-ones low bits mark the tick.
  function automatic logic main_tick(input logic [2:0]    code,
                                     input logic [PW-1:0] pre);
    case (code)
      pulse_gen_pkg::CK_DIV2048: main_tick = &pre[10:0];
      pulse_gen_pkg::CK_DIV1024: main_tick = &pre[9:0];
      pulse_gen_pkg::CK_DIV256:  main_tick = &pre[7:0];
      pulse_gen_pkg::CK_DIV64:   main_tick = &pre[5:0];
      pulse_gen_pkg::CK_DIV16:   main_tick = &pre[3:0];
      pulse_gen_pkg::CK_DIV4:    main_tick = &pre[1:0];
      pulse_gen_pkg::CK_DIV2:    main_tick = pre[0];
      pulse_gen_pkg::CK_DIV1:    main_tick = 1'b1;
      default:                   main_tick = 1'b0;
    endcase
  endfunction

  // Decoding of APB address to register select.
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  wire logic access   = psel & penable & pready_q;
  wire logic wr_en    = access & pwrite & ~pslverr_q;
  wire logic mapped   = hit(paddr, pulse_gen_pkg::OFS_CTRL)
                      | hit(paddr, pulse_gen_pkg::OFS_MODE)
                      | hit(paddr, pulse_gen_pkg::OFS_CYC_LO)
                      | hit(paddr, pulse_gen_pkg::OFS_CYC_HI)
                      | hit(paddr, pulse_gen_pkg::OFS_DUTY_LO)
                      | hit(paddr, pulse_gen_pkg::OFS_DUTY_HI)
                      | hit(paddr, pulse_gen_pkg::OFS_SYS)
                      | hit(paddr, pulse_gen_pkg::OFS_STATUS);
  wire logic wr_ctrl  = wr_en & hit(paddr, pulse_gen_pkg::OFS_CTRL);
  wire logic wr_mode  = wr_en & hit(paddr, pulse_gen_pkg::OFS_MODE);
  wire logic wr_cl    = wr_en & hit(paddr, pulse_gen_pkg::OFS_CYC_LO);
  wire logic wr_ch    = wr_en & hit(paddr, pulse_gen_pkg::OFS_CYC_HI);
  wire logic wr_dl    = wr_en & hit(paddr, pulse_gen_pkg::OFS_DUTY_LO);
  wire logic wr_sys   = wr_en & hit(paddr, pulse_gen_pkg::OFS_SYS);
  wire logic commit   = wr_en & hit(paddr, pulse_gen_pkg::OFS_DUTY_HI); // RQ7 RQ8

  // Only the upper timer's fields are looked at once cascaded.
  wire logic running  = ctrl_q.run_bit & ctrl_q.cascade_select // RQ1
                      & (mode_q.mode_field == pulse_gen_pkg::MODE_PPG16); // RQ2

  wire logic fs_edge  = low_freq_clock & ~fs_prev_q;
  wire logic ext_edge = ext_clock_in & ~ext_prev_q; // RQ6
  wire logic fs_tap16 = fs_edge & (&fsdiv_q);
  wire logic fs_tap8  = fs_edge & (&fsdiv_q[2:0]);
  wire logic fs_tap4  = fs_edge & (&fsdiv_q[1:0]);
  wire logic code0    = mode_q.clock_select_field == pulse_gen_pkg::CK_DIV2048;
  wire logic code1    = mode_q.clock_select_field == pulse_gen_pkg::CK_DIV1024;
  wire logic code7    = mode_q.clock_select_field == pulse_gen_pkg::CK_DIV1;
  wire logic low_sel  = sys_q.slow_mode
                      | (sys_q.divider_select_bit & (code0 | code1)); // RQ5
  wire logic low_tick = code0 ? fs_tap16 :
                        code1 ? fs_tap8 :
                        (code7 & sys_q.slow_mode) ? fs_tap4 : 1'b0; // RQ5
  wire logic int_tick = low_sel ? low_tick
                      : main_tick(mode_q.clock_select_field, pre_q); // RQ4
  wire logic src_tick = mode_q.external_clock_select ? ext_edge
                      : int_tick; // RQ3

  wire logic [15:0] new_cyc  = {cyc_hi_q, cyc_lo_q};
  wire logic [15:0] new_duty = {pwdata[7:0], duty_lo_q};
  // Running with the buffer on defers the comparators to the boundary.
  wire logic defer    = mode_q.double_buffer_enable & running; // RQ14
  wire logic load_now = commit & ~defer; // RQ16 RQ17
  wire logic cyc_hit  = running & check_q
                      & (cnt_q == act_q.cycle_value16); // RQ12 RQ18
  wire logic duty_hit = running & check_q
                      & (cnt_q == act_q.duty_value16); // RQ11 RQ18

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = pulse_gen_pkg::WORD_ZERO;
    case (paddr)
      pulse_gen_pkg::OFS_CTRL:    rd_mux[7:0] = ctrl_q;
      pulse_gen_pkg::OFS_MODE:    rd_mux[7:0] = mode_q;
      pulse_gen_pkg::OFS_CYC_LO:  rd_mux[7:0] = cyc_lo_q;  // RQ20
      pulse_gen_pkg::OFS_CYC_HI:  rd_mux[7:0] = cyc_hi_q;  // RQ20
      pulse_gen_pkg::OFS_DUTY_LO: rd_mux[7:0] = duty_lo_q; // RQ20
      pulse_gen_pkg::OFS_DUTY_HI: rd_mux[7:0] = duty_hi_q; // RQ20
      pulse_gen_pkg::OFS_SYS:     rd_mux[7:0] = sys_q;
      pulse_gen_pkg::OFS_STATUS:  rd_mux[17:0] = {running, pin_q, cnt_q};
      default:                    rd_mux = pulse_gen_pkg::WORD_ZERO;
    endcase
  end

  // Next values; each register below only takes its own next value.
  wire logic        setup     = psel & ~penable;
  wire logic        pready_d  = setup;
  wire logic        pslverr_d = setup & ~mapped;
  // The answer is latched in the setup cycle, so access never waits.
  wire logic [31:0] prdata_d  = !setup ? prdata_q
                              : pwrite ? pulse_gen_pkg::WORD_ZERO
                              : rd_mux;

  pulse_gen_pkg::pair_ctrl_t    ctrl_d;
  pulse_gen_pkg::upper_mode_t   mode_d;
  pulse_gen_pkg::sys_ctrl_t     sys_d;
  pulse_gen_pkg::compare_pair_t commit_val;
  pulse_gen_pkg::compare_pair_t buf_d;
  pulse_gen_pkg::compare_pair_t act_d;
  assign ctrl_d = wr_ctrl ? pulse_gen_pkg::pair_ctrl_t'(pwdata[7:0])
                          : ctrl_q;
  assign mode_d = wr_mode ? pulse_gen_pkg::upper_mode_t'(pwdata[7:0])
                          : mode_q;
  assign sys_d  = wr_sys  ? pulse_gen_pkg::sys_ctrl_t'(pwdata[7:0])
                          : sys_q;
  wire logic [7:0]  cyc_lo_d  = wr_cl  ? pwdata[7:0] : cyc_lo_q;
  wire logic [7:0]  cyc_hi_d  = wr_ch  ? pwdata[7:0] : cyc_hi_q;
  wire logic [7:0]  duty_lo_d = wr_dl  ? pwdata[7:0] : duty_lo_q;
  wire logic [7:0]  duty_hi_d = commit ? pwdata[7:0] : duty_hi_q; // RQ7

  wire logic [PW-1:0] pre_d   = pre_q + 1'b1;
  wire logic [FW-1:0] fsdiv_d = fs_edge ? fsdiv_q + 1'b1 : fsdiv_q;

  // Both copies take a commit; the active one waits when deferred.
  wire logic boundary = cyc_hit & mode_q.double_buffer_enable; // RQ21
  assign commit_val = '{cycle_value16: new_cyc, duty_value16: new_duty};
  assign buf_d      = commit ? commit_val : buf_q; // RQ15 RQ16
  assign act_d      = load_now ? commit_val // RQ16 RQ17
                    : boundary ? buf_q // RQ15 RQ21
                    : act_q;

  // A cycle match or a stop clears the count and restores the pin.
  wire logic        restart    = ~running | cyc_hit; // RQ12 RQ13
  wire logic [15:0] cnt_inc    = cnt_q + 1'b1; // RQ22
  wire logic [15:0] cnt_d      = restart  ? pulse_gen_pkg::COUNT_ZERO
                               : src_tick ? cnt_inc // RQ10
                               : cnt_q;
  // A fresh load equal to the count matches at once, off the grid.
  wire logic        check_d    = ~restart & (src_tick | load_now); // RQ19
  wire logic        pin_d      = restart  ? mode_q.initial_level_bit // RQ9
                               : duty_hit ? ~mode_q.initial_level_bit // RQ11
                               : pin_q;
  wire logic        duty_irq_d = duty_hit & ~cyc_hit; // RQ11
  wire logic        cyc_irq_d  = cyc_hit; // RQ12 RQ15

  // One register per process, each cleared by the reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= pulse_gen_pkg::WORD_ZERO;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= pslverr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= '0;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_q <= '0;
    end else begin
      sys_q <= sys_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_lo_q <= pulse_gen_pkg::BYTE_ZERO;
    end else begin
      cyc_lo_q <= cyc_lo_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_hi_q <= pulse_gen_pkg::BYTE_ZERO;
    end else begin
      cyc_hi_q <= cyc_hi_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_lo_q <= pulse_gen_pkg::BYTE_ZERO;
    end else begin
      duty_lo_q <= duty_lo_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_hi_q <= pulse_gen_pkg::BYTE_ZERO;
    end else begin
      duty_hi_q <= duty_hi_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsdiv_q <= '0;
    end else begin
      fsdiv_q <= fsdiv_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_prev_q <= 1'b0;
    end else begin
      fs_prev_q <= low_freq_clock;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_clock_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_q <= '0;
    end else begin
      buf_q <= buf_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= '0;
    end else begin
      act_q <= act_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= pulse_gen_pkg::COUNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      check_q <= 1'b0;
    end else begin
      check_q <= check_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_irq_q <= 1'b0;
    end else begin
      duty_irq_q <= duty_irq_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_irq_q <= 1'b0;
    end else begin
      cyc_irq_q <= cyc_irq_d;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign pulse_output_pin = pin_q;
  assign duty_match_irq   = duty_irq_q;
  assign cycle_match_irq  = cyc_irq_q;
endmodule
`default_nettype wire

// ==== pulse_gen_assertions.sv ====
// Checker of port timing for the pulse generator, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module pulse_gen_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        duty_match_irq,
  input wire logic        cycle_match_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_after_setup:
    assert property (psel && !penable |=> pready) else $error("late ready");
  a_ready_one_cycle:
    assert property (pready |=> !pready) else $error("ready too long");
  a_ready_in_access:
    assert property (pready |-> psel && penable) else $error("stray ready");
  a_err_reads_zero:
    assert property (pready && pslverr |-> prdata == 32'h0000_0000)
      else $error("error read not zero");
  a_mapped_no_err:
    assert property (pready && paddr <= 8'h1C && paddr[1:0] == 2'h0
      |-> !pslverr) else $error("error on mapped word");
  a_write_data_zero:
    assert property (pready && pwrite |-> prdata == 32'h0000_0000)
      else $error("write returned data");
  a_duty_irq_pulse:
    assert property (duty_match_irq |=> !duty_match_irq)
      else $error("duty irq too long");
  a_cycle_irq_pulse:
    assert property (cycle_match_irq |=> !cycle_match_irq)
      else $error("cycle irq too long");
  a_irq_exclusive:
    assert property (!(duty_match_irq && cycle_match_irq))
      else $error("both irqs at once");
endmodule
bind pulse_gen pulse_gen_assertions pulse_gen_assertions_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .duty_match_irq, .cycle_match_irq);
`default_nettype wire

// ==== pulse_gen_bench.sv ====
// Self-checking bench for the cascaded pulse generator.
`timescale 1ns/1ps
`default_nettype none
module pulse_gen_bench;
  logic        pclk, presetn, psel, penable, pwrite, err, ext_en;
  logic [7:0]  paddr;
  logic [3:0]  k;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, low_freq_clock, ext_clock_in;
  logic        pulse_output_pin, duty_match_irq, cycle_match_irq;
  int          error_cnt, samples_checked, cyc, a, b, c;
  pulse_gen pulse_gen_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .low_freq_clock, .ext_clock_in,
    .pulse_output_pin, .duty_match_irq, .cycle_match_irq);
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // External count clock has two pclk per phase when enabled.
  always @(posedge pclk) begin
    k <= k + 4'h1;
    cyc <= cyc + 1;
    low_freq_clock <= k[3];
    ext_clock_in <= ext_en & k[1];
  end
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= {24'hFFFF_FF, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    err = pslverr;
    if (n >= 40) error_cnt++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic prog(input logic [15:0] cv, input logic [15:0] dv);
    apb(1'b1, pulse_gen_pkg::OFS_CYC_LO, cv[7:0]);
    apb(1'b1, pulse_gen_pkg::OFS_CYC_HI, cv[15:8]);
    apb(1'b1, pulse_gen_pkg::OFS_DUTY_LO, dv[7:0]);
    apb(1'b1, pulse_gen_pkg::OFS_DUTY_HI, dv[15:8]);
  endtask
  task automatic wait_for(ref logic s, input logic v, output int at);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (s !== v && n < 600);
    if (n >= 600) error_cnt++;
    at = cyc;
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, ext_en} = 5'h00;
    {paddr, pwdata, k, cyc} = '0;
    {low_freq_clock, ext_clock_in} = 2'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, pulse_gen_pkg::OFS_STATUS, 8'h00);
    check("status reset", rd, 32'h0000_0000);
    apb(1'b0, 8'h20, 8'h00);
    check("unmapped err", {31'h0, err}, 32'h0000_0001);
    prog(16'h0006, 16'h0003);
    apb(1'b0, pulse_gen_pkg::OFS_CYC_LO, 8'h00);
    check("cycle low read", rd, 32'h0000_0006);
    apb(1'b0, pulse_gen_pkg::OFS_DUTY_LO, 8'h00);
    check("duty low read", rd, 32'h0000_0003);
    apb(1'b1, pulse_gen_pkg::OFS_MODE, 8'hB7);
    @(posedge pclk);
    check("idle pin high", {31'h0, pulse_output_pin}, 32'h1);
    apb(1'b1, pulse_gen_pkg::OFS_MODE, 8'h37);
    @(posedge pclk);
    check("idle pin low", {31'h0, pulse_output_pin}, 32'h0);
    apb(1'b1, pulse_gen_pkg::OFS_CTRL, 8'h03);
    apb(1'b0, pulse_gen_pkg::OFS_STATUS, 8'h00);
    check("running", {31'h0, rd[17]}, 32'h1);
    wait_for(pulse_output_pin, 1'b1, a);
    wait_for(pulse_output_pin, 1'b0, b);
    check("pin high width", b - a, 3);
    wait_for(cycle_match_irq, 1'b1, a);
    wait_for(cycle_match_irq, 1'b1, b);
    check("period div1", b - a, 7);
    apb(1'b1, pulse_gen_pkg::OFS_CTRL, 8'h02);
    apb(1'b0, pulse_gen_pkg::OFS_STATUS, 8'h00);
    check("stopped status", rd, 32'h0000_0000);
    apb(1'b1, pulse_gen_pkg::OFS_CTRL, 8'h01);
    apb(1'b0, pulse_gen_pkg::OFS_STATUS, 8'h00);
    check("no cascade", rd, 32'h0000_0000);
    apb(1'b1, pulse_gen_pkg::OFS_MODE, 8'h27);
    apb(1'b1, pulse_gen_pkg::OFS_CTRL, 8'h03);
    apb(1'b0, pulse_gen_pkg::OFS_STATUS, 8'h00);
    check("other mode", rd, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      ext_en <= i[0];
      apb(1'b1, pulse_gen_pkg::OFS_MODE, i ? 8'h3F : 8'h35);
      wait_for(cycle_match_irq, 1'b1, a);
      wait_for(cycle_match_irq, 1'b1, b);
      check("period by four", b - a, 24);
    end
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, pulse_gen_pkg::OFS_CTRL, 8'h02);
      apb(1'b1, pulse_gen_pkg::OFS_MODE, i ? 8'h37 : 8'h77);
      prog(16'h0014, 16'h000A);
      apb(1'b1, pulse_gen_pkg::OFS_CTRL, 8'h03);
      wait_for(cycle_match_irq, 1'b1, a);
      prog(16'h001E, 16'h000F);
      wait_for(cycle_match_irq, 1'b1, b);
      check("commit period", b - a, i ? 31 : 21);
      wait_for(cycle_match_irq, 1'b1, c);
      check("new period", c - b, 31);
      apb(1'b0, pulse_gen_pkg::OFS_CYC_LO, 8'h00);
      check("cycle read", rd, 32'h0000_001E);
    end
    // Low-frequency ticks: fs/8 via the divider bit, then fs/4 when slow.
    apb(1'b1, pulse_gen_pkg::OFS_CTRL, 8'h02);
    prog(16'h0002, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, pulse_gen_pkg::OFS_SYS, i ? 8'h02 : 8'h01);
      apb(1'b1, pulse_gen_pkg::OFS_MODE, i ? 8'h37 : 8'h31);
      apb(1'b1, pulse_gen_pkg::OFS_CTRL, 8'h03);
      wait_for(cycle_match_irq, 1'b1, a);
      wait_for(duty_match_irq, 1'b1, c);
      check("low duty", c - a, i ? 64 : 128);
      wait_for(cycle_match_irq, 1'b1, b);
      check("low period", b - a, i ? 128 : 256);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
